// file: src/hbc_compare.sv
// Hardware breakpoint comparator watching the core address, data and read/write lines.
// Assumes the core and debug controller share this clock; inputs need no synchronising.
//
// Function
// RULE1: Mode field selects off, swi dual, full, debug dual
// RULE2: First address pair always compared in enabled modes
// RULE3: Data pair: address in dual, data in full
// RULE4: No matches while debug mode is active
// RULE5: Debug entry only when debug enable asserted
// RULE6: Software picks debug modes only when enabled; control A takes any mode write regardless of enable
// RULE7: Debug dual: each address fully qualified
// RULE8: Data compare enable gates second address
// RULE9: Eight-bit size bit ignored in dual modes
// RULE10: Program-only bit restricts breaks to executed opcodes
// RULE11: Swi dual mode always program fetch only
// RULE12: First range bit: high byte or full address
// RULE13: Second range bit adds low data register
// RULE14: Data compare enable off excludes data pair
// RULE15: High byte mask drops data bits 15:8
// RULE16: Low byte mask drops data bits 7:0
// RULE17: Second rw qualify only in dual with enable
// RULE18: Second rw value 0 write, 1 read
// RULE19: Control A resets zero, always readable, writable
// RULE20: First rw qualify: 0 write, 1 read
// RULE21: Swi dual match forces software interrupt
// RULE22: Single registered request, cleared on ack or debug
`timescale 1ns/10ps
module hbc_compare (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire hbc_pkg::hbc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Core bus cycle
  input wire hbc_pkg::hbc_cycle_t bus,
  // Debug controller status
  input wire logic dbg_active,
  input wire logic dbg_enable,
  // Break request toward the core
  input wire logic brk_ack,
  output logic brk_req,
  output logic brk_is_swi
);
  import hbc_pkg::*;

  // Register storage
  logic [7:0] ctl_a_reg; // Mode, program-only and range bits
  logic [7:0] ctl_b_reg; // Data enable, masks and read/write qualifiers
  logic [7:0] ah_reg; // First address compare, high byte
  logic [7:0] al_reg; // First address compare, low byte
  logic [7:0] dh_reg; // Data pair high byte, also second address high
  logic [7:0] dl_reg; // Data pair low byte, also second address low
  logic [7:0] rdata_reg;
  logic req_reg;
  hbc_kind_t kind_reg;

  // Address decode
  wire sel_a = reg_req.addr == HBC_OFS_CTL_A;
  wire sel_b = reg_req.addr == HBC_OFS_CTL_B;
  wire sel_ah = reg_req.addr == HBC_OFS_AH;
  wire sel_al = reg_req.addr == HBC_OFS_AL;
  wire sel_dh = reg_req.addr == HBC_OFS_DH;
  wire sel_dl = reg_req.addr == HBC_OFS_DL;

  // Read mux; unmapped offsets read zero
  wire [7:0] rd_mux = sel_a ? ctl_a_reg : sel_b ? ctl_b_reg : sel_ah ? ah_reg :
    sel_al ? al_reg : sel_dh ? dh_reg : sel_dl ? dl_reg : HBC_RST_BYTE;

  // Field decode
  wire [1:0] mode = {ctl_a_reg[HBC_A_MODE_HI], ctl_a_reg[HBC_A_MODE_LO]}; // see RULE1
  wire prog_only = ctl_a_reg[HBC_A_PROG];
  wire range1 = ctl_a_reg[HBC_A_RANGE1];
  wire range2 = ctl_a_reg[HBC_A_RANGE2];
  wire dce = ctl_b_reg[HBC_B_DCE];
  wire mask_h = ctl_b_reg[HBC_B_MASKH];
  wire mask_l = ctl_b_reg[HBC_B_MASKL];
  wire rwq2 = ctl_b_reg[HBC_B_RWQ2];
  wire rwv2 = ctl_b_reg[HBC_B_RWV2];
  wire rwq1 = ctl_b_reg[HBC_B_RWQ1];
  wire rwv1 = ctl_b_reg[HBC_B_RWV1];

  wire mode_swi = mode == HBC_MODE_SWI_DUAL;
  wire mode_full = mode == HBC_MODE_FULL;
  wire mode_dual = mode_swi || (mode == HBC_MODE_DBG_DUAL);
  // Size bit is not decoded anywhere, so dual modes cannot see it; see RULE9

  // First address compare, low byte only when range bit set
  wire hi1 = bus.addr[15:8] == ah_reg; // see RULE2
  wire lo1 = !range1 || (bus.addr[7:0] == al_reg); // see RULE12
  // First read/write qualifier; swi mode ignores it
  wire rw1 = mode_swi || !rwq1 || (bus.rd == rwv1); // see RULE20

  // Second address compare against data pair
  wire hi2 = bus.addr[15:8] == dh_reg; // see RULE3
  wire lo2 = !range2 || (bus.addr[7:0] == dl_reg); // see RULE13
  wire rw2 = mode_swi || !rwq2 || (bus.rd == rwv2); // see RULE17 see RULE18

  // Full mode data compare with byte masks
  wire dhi = mask_h || (bus.data[15:8] == dh_reg); // see RULE15
  wire dlo = mask_l || (bus.data[7:0] == dl_reg); // see RULE16

  // Program qualification: swi always needs an executed fetch
  wire need_prog = mode_swi || prog_only; // see RULE11
  wire prog_ok = !need_prog || (bus.fetch && bus.exec); // see RULE10

  // Per-breakpoint hits
  wire hit1 = hi1 && lo1 && rw1; // see RULE7
  wire hit2 = mode_dual && dce && hi2 && lo2 && rw2; // see RULE8 see RULE14
  wire hit_full = mode_full && hi1 && lo1 && rw1 && (!dce || (dhi && dlo)); // see RULE3
  wire any_hit = (mode_dual && (hit1 || hit2)) || hit_full;

  // Qualified match, suppressed while debug is active
  wire match = bus.valid && prog_ok && any_hit && !dbg_active; // see RULE4
  // Debug entry needs the enable; swi needs none
  wire fire = match && (mode_swi || dbg_enable); // see RULE5 see RULE21

  // Register writes; control A read/write at any time
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctl_a_reg <= HBC_RST_BYTE; // see RULE19
      ctl_b_reg <= HBC_RST_BYTE;
      ah_reg <= HBC_RST_BYTE;
      al_reg <= HBC_RST_BYTE;
      dh_reg <= HBC_RST_BYTE;
      dl_reg <= HBC_RST_BYTE;
    end else if (reg_req.wr) begin
      if (sel_a) ctl_a_reg <= reg_req.wdata & HBC_MASK_CTL_A; // see RULE19
      if (sel_b) ctl_b_reg <= reg_req.wdata & HBC_MASK_CTL_B;
      if (sel_ah) ah_reg <= reg_req.wdata;
      if (sel_al) al_reg <= reg_req.wdata;
      if (sel_dh) dh_reg <= reg_req.wdata;
      if (sel_dl) dl_reg <= reg_req.wdata;
    end
  end

  // Read data, valid the cycle after the read strobe only
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata_reg <= HBC_RST_BYTE;
    end else begin
      rdata_reg <= reg_req.rd ? rd_mux : HBC_RST_BYTE;
    end
  end

  // Break request: a new match sets it only when none is held, over any clear; see RULE22
  always_ff @(posedge clock) begin
    if (!nrst) begin
      req_reg <= 1'b0;
      kind_reg <= HBC_KIND_DEBUG;
    end else if (fire && !req_reg) begin
      req_reg <= 1'b1;
      kind_reg <= mode_swi ? HBC_KIND_SWI : HBC_KIND_DEBUG;
    end else if (brk_ack || dbg_active) begin
      req_reg <= 1'b0; // see RULE22
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_reg;
  assign brk_req = req_reg;
  assign brk_is_swi = kind_reg == HBC_KIND_SWI;

  // Mode 00 never raises a request
  a_off_no_req: assert property ( // see RULE1
    @(posedge clock) disable iff (!nrst)
    (mode == HBC_MODE_OFF && !req_reg) |=> !req_reg)
    else $error("request in off mode");

  // Nothing fires while the core runs debug code
  a_active_blocks: assert property ( // see RULE4
    @(posedge clock) disable iff (!nrst)
    (dbg_active && !req_reg) |=> !req_reg)
    else $error("request while debug active");

  // Debug entry needs the enable indication
  a_enable_gate: assert property ( // see RULE5
    @(posedge clock) disable iff (!nrst)
    (!req_reg && !dbg_enable && !mode_swi) |=> !req_reg)
    else $error("debug request without enable");

  // A software interrupt match raises a software request
  a_swi_kind: assert property ( // see RULE21
    @(posedge clock) disable iff (!nrst)
    (!req_reg && match && mode_swi) |=> (req_reg && brk_is_swi))
    else $error("swi match missed");

  // Acknowledge ends the request
  a_ack_clears: assert property ( // see RULE22
    @(posedge clock) disable iff (!nrst)
    (req_reg && brk_ack) |=> !req_reg)
    else $error("ack did not clear");

  // Debug entry ends the request as well
  a_dbg_clears: assert property ( // see RULE22
    @(posedge clock) disable iff (!nrst)
    (req_reg && dbg_active) |=> !req_reg)
    else $error("debug entry did not clear");

  // Request outputs are idle after reset
  a_req_reset: assert property ( // see RULE22
    @(posedge clock)
    !nrst |=> (!brk_req && !brk_is_swi))
    else $error("request not reset");

  // Control A comes out of reset as zero
  a_ctla_reset: assert property ( // see RULE19
    @(posedge clock)
    !nrst |=> (ctl_a_reg == HBC_RST_BYTE))
    else $error("control a not reset");

  // Control A takes every write
  a_ctla_write: assert property ( // see RULE19
    @(posedge clock) disable iff (!nrst)
    (reg_req.wr && sel_a) |=> (ctl_a_reg == ($past(reg_req.wdata) & HBC_MASK_CTL_A)))
    else $error("control a write lost");

  // Read data is zero unless a read came the cycle before
  a_rdata_idle: assert property ( // see RULE19
    @(posedge clock) disable iff (!nrst)
    !reg_req.rd |=> (reg_rdata == HBC_RST_BYTE))
    else $error("read data outside its cycle");

  // Software interrupt mode breaks only on executed fetches
  a_swi_prog: assert property ( // see RULE11
    @(posedge clock) disable iff (!nrst)
    (!req_reg && mode_swi && !(bus.fetch && bus.exec)) |=> !req_reg)
    else $error("swi on non-fetch");

  // Program-only bit blocks data cycles
  a_prog_only: assert property ( // see RULE10
    @(posedge clock) disable iff (!nrst)
    (!req_reg && prog_only && !bus.fetch) |=> !req_reg)
    else $error("break on a data cycle");

  // Second address needs the data compare enable
  a_dce_off: assert property ( // see RULE8
    @(posedge clock) disable iff (!nrst)
    (!dce && mode_dual && !hit1) |-> !any_hit)
    else $error("second address without enable");

  // Range bit clear: the high byte alone makes a hit
  a_range1_off: assert property ( // see RULE12
    @(posedge clock) disable iff (!nrst)
    (!req_reg && mode_swi && !range1 && bus.valid && bus.fetch && bus.exec &&
      !dbg_active && bus.addr[15:8] == ah_reg) |=> req_reg)
    else $error("high byte match missed");

  // Second range bit set: the low data byte must match too
  a_range2_on: assert property ( // see RULE13
    @(posedge clock) disable iff (!nrst)
    (!req_reg && mode == HBC_MODE_DBG_DUAL && range2 && bus.addr[7:0] != dl_reg &&
      bus.addr[15:8] != ah_reg) |=> !req_reg)
    else $error("second range ignored low byte");

  // Full mode always needs the first address
  a_full_addr: assert property ( // see RULE3
    @(posedge clock) disable iff (!nrst)
    (!req_reg && mode_full && bus.addr[15:8] != ah_reg) |=> !req_reg)
    else $error("full break without address");

  // Full mode with all fields matching gives a debug request
  a_full_fires: assert property ( // see RULE2
    @(posedge clock) disable iff (!nrst)
    (!req_reg && mode_full && dbg_enable && !dbg_active && bus.valid && !prog_only &&
      dce && !mask_h && !mask_l && !rwq1 && range1 && bus.addr == {ah_reg, al_reg} &&
      bus.data == {dh_reg, dl_reg}) |=> (req_reg && !brk_is_swi))
    else $error("full match missed");

  // Unmasked high data byte must match
  a_mask_high: assert property ( // see RULE15
    @(posedge clock) disable iff (!nrst)
    (!req_reg && mode_full && dce && !mask_h && bus.data[15:8] != dh_reg) |=> !req_reg)
    else $error("high data byte ignored");

  // Unmasked low data byte must match
  a_mask_low: assert property ( // see RULE16
    @(posedge clock) disable iff (!nrst)
    (!req_reg && mode_full && dce && !mask_l && bus.data[7:0] != dl_reg) |=> !req_reg)
    else $error("low data byte ignored");

  // First qualifier set for writes refuses read cycles
  a_rw1_write: assert property ( // see RULE20
    @(posedge clock) disable iff (!nrst)
    (!req_reg && !mode_swi && rwq1 && !rwv1 && bus.rd && (mode_full || !dce)) |=> !req_reg)
    else $error("first qualifier ignored");

  // Second qualifier set for reads refuses write cycles
  a_rw2_read: assert property ( // see RULE18
    @(posedge clock) disable iff (!nrst)
    (!req_reg && mode == HBC_MODE_DBG_DUAL && rwq2 && rwv2 && !bus.rd &&
      bus.addr[15:8] != ah_reg) |=> !req_reg)
    else $error("second qualifier ignored");

  // Software break seen
  c_swi_break: cover property (
    @(posedge clock) disable iff (!nrst)
    req_reg && brk_is_swi);

  // Debug break seen
  c_dbg_break: cover property (
    @(posedge clock) disable iff (!nrst)
    req_reg && !brk_is_swi);

  // Full mode break seen
  c_full_hit: cover property (
    @(posedge clock) disable iff (!nrst)
    fire && mode_full);

  // Second address alone breaks
  c_second_hit: cover property (
    @(posedge clock) disable iff (!nrst)
    fire && hit2 && !hit1);

endmodule : hbc_compare

// file: src/hbc_pkg.sv
// Package for the hardware breakpoint comparator: register map, field layout, modes.
// Assumes a 16-bit core bus and a plain strobe-based register port.
package hbc_pkg;

  // Register offsets, one byte register per address
  localparam logic [15:0] HBC_OFS_CTL_A = 16'h0020; // breakpoint_control_a
  localparam logic [15:0] HBC_OFS_CTL_B = 16'h0021; // breakpoint_control_b
  localparam logic [15:0] HBC_OFS_AH = 16'h0022; // addr_compare_high
  localparam logic [15:0] HBC_OFS_AL = 16'h0023; // addr_compare_low
  localparam logic [15:0] HBC_OFS_DH = 16'h0024; // data_compare_high
  localparam logic [15:0] HBC_OFS_DL = 16'h0025; // data_compare_low

  // Reset values
  localparam logic [7:0] HBC_RST_BYTE = 8'h00;

  // Writable bit masks; unused bits read as zero
  localparam logic [7:0] HBC_MASK_CTL_A = 8'hec;
  localparam logic [7:0] HBC_MASK_CTL_B = 8'hff;

  // Control A field positions
  localparam int HBC_A_MODE_HI = 7;
  localparam int HBC_A_MODE_LO = 6;
  localparam int HBC_A_PROG = 5;
  localparam int HBC_A_RANGE2 = 3;
  localparam int HBC_A_RANGE1 = 2;

  // Control B field positions
  localparam int HBC_B_SIZE8 = 7;
  localparam int HBC_B_DCE = 6;
  localparam int HBC_B_MASKH = 5;
  localparam int HBC_B_MASKL = 4;
  localparam int HBC_B_RWQ2 = 3;
  localparam int HBC_B_RWV2 = 2;
  localparam int HBC_B_RWQ1 = 1;
  localparam int HBC_B_RWV1 = 0;

  // Break mode encodings
  localparam logic [1:0] HBC_MODE_OFF = 2'h0;
  localparam logic [1:0] HBC_MODE_SWI_DUAL = 2'h1;
  localparam logic [1:0] HBC_MODE_FULL = 2'h2;
  localparam logic [1:0] HBC_MODE_DBG_DUAL = 2'h3;

  // Kind of break request held toward the core
  typedef enum logic {HBC_KIND_DEBUG, HBC_KIND_SWI} hbc_kind_t;

  // One bus cycle as seen from the core
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
    logic rd; // 1 read, 0 write
    logic valid; // Cycle valid this clock
    logic fetch; // Cycle is an opcode fetch
    logic exec; // Fetched opcode will execute
  } hbc_cycle_t;

  // Register access port
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } hbc_reg_req_t;

endpackage : hbc_pkg

// file: test/hbc_core_model.sv
// Behavioural model of the core and debug controller beside the breakpoint comparator.
// Assumes the comparator clock and reset; acks software breaks, enters debug for others.
`timescale 1ns/10ps
module hbc_core_model (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Break request from the comparator
  input wire logic brk_req,
  input wire logic brk_is_swi,
  // Bench controls: answer delay and a held debug state
  input wire logic [2:0] dly,
  input wire logic dbg_force,
  // Answers toward the comparator
  output logic brk_ack,
  output logic dbg_active
);
  logic [2:0] cnt_reg; // Cycles the request has waited
  logic [2:0] stay_reg; // Cycles left inside debug code

  // Debug is active while the stay runs or the bench holds it
  assign dbg_active = (stay_reg != 3'h0) | dbg_force;

  // Answer a request after dly cycles: ack a software break, enter debug otherwise
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnt_reg <= 3'h0;
      stay_reg <= 3'h0;
      brk_ack <= 1'b0;
    end else begin
      brk_ack <= 1'b0;
      if (stay_reg != 3'h0) begin
        // Debug code runs, then returns to normal flow unserviced
        stay_reg <= stay_reg - 3'h1;
      end else if (brk_req && !brk_ack) begin
        if (cnt_reg == dly) begin
          cnt_reg <= 3'h0;
          if (brk_is_swi) begin
            brk_ack <= 1'b1;
          end else begin
            stay_reg <= 3'h4;
          end
        end else begin
          cnt_reg <= cnt_reg + 3'h1;
        end
      end else begin
        cnt_reg <= 3'h0;
      end
    end
  end
endmodule : hbc_core_model

// file: test/tb_top.sv
// Self-checking bench for the breakpoint comparator: table of match cases, then hand tests.
// Assumes the core model in its own file and the package constants for offsets.
`timescale 1ns/10ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_top;
  import hbc_pkg::*;
  // One table row: controls, bus cycle, flags {rd,fetch,exec,enable}, expect {req,swi}
  typedef struct packed {
    logic [7:0] a, b;
    logic [15:0] ba, bd;
    logic [3:0] f;
    logic [1:0] e;
  } hbc_row_t;
  logic clock, nrst, dbg_active, dbg_enable, dbg_force, brk_ack, brk_req, brk_is_swi;
  logic [2:0] dly;
  logic [7:0] reg_rdata;
  hbc_reg_req_t req;
  hbc_cycle_t bus;
  int fail_count = 0;
  int cmp_count = 0;
  hbc_row_t rows [18] = '{
    '{8'h00, 8'h00, 16'h1234, 16'h0, 4'h7, 2'h0},
    '{8'h44, 8'h00, 16'h1234, 16'h0, 4'h6, 2'h3},
    '{8'h44, 8'h00, 16'h1234, 16'h0, 4'h4, 2'h0},
    '{8'h44, 8'hc0, 16'h5678, 16'h0, 4'h6, 2'h3},
    '{8'h40, 8'h00, 16'h12ff, 16'h0, 4'h6, 2'h3},
    '{8'hc4, 8'h00, 16'h5678, 16'h0, 4'h7, 2'h0},
    '{8'hcc, 8'h40, 16'h56ff, 16'h0, 4'h7, 2'h0},
    '{8'hc8, 8'h40, 16'h5678, 16'h0, 4'h1, 2'h2},
    '{8'hec, 8'h00, 16'h1234, 16'h0, 4'h1, 2'h0},
    '{8'hcc, 8'h4c, 16'h5678, 16'h0, 4'h1, 2'h0},
    '{8'hcc, 8'h4c, 16'h5678, 16'h0, 4'h9, 2'h2},
    '{8'hc4, 8'h03, 16'h1234, 16'h0, 4'h1, 2'h0},
    '{8'hc4, 8'h00, 16'h1299, 16'h0, 4'h1, 2'h0},
    '{8'h84, 8'h40, 16'h1234, 16'h5678, 4'h1, 2'h2},
    '{8'h84, 8'h40, 16'h1234, 16'h5600, 4'h1, 2'h0},
    '{8'h84, 8'h50, 16'h1234, 16'h5600, 4'h1, 2'h2},
    '{8'h84, 8'h60, 16'h1234, 16'h0078, 4'h1, 2'h2},
    '{8'h84, 8'h00, 16'h1234, 16'h0, 4'h0, 2'h0}};

  // Design and far-side model
  hbc_compare dut (.clock(clock), .nrst(nrst), .reg_req(req), .reg_rdata(reg_rdata),
    .bus(bus), .dbg_active(dbg_active), .dbg_enable(dbg_enable), .brk_ack(brk_ack),
    .brk_req(brk_req), .brk_is_swi(brk_is_swi));
  hbc_core_model core (.clock(clock), .nrst(nrst), .brk_req(brk_req),
    .brk_is_swi(brk_is_swi), .dly(dly), .dbg_force(dbg_force), .brk_ack(brk_ack),
    .dbg_active(dbg_active));

  // Clock at 4 ns
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Prints the counts and the verdict, then stops
  task test_done();
    $display("checks %0d errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  // One register write cycle
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    req.addr <= a; req.wdata <= d; req.wr <= 1'b1;
    @(posedge clock);
    req.wr <= 1'b0;
  endtask : wr

  // One register read; data stands only in the following cycle
  task rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock);
    req.addr <= a; req.rd <= 1'b1;
    @(posedge clock);
    req.rd <= 1'b0;
    #1 `CHK("reg_rdata", exp, reg_rdata)
  endtask : rd

  // Set controls, present n valid bus cycles, check the request, wait for it to clear
  task cyc(input hbc_row_t r, input int n);
    int k;
    wr(HBC_OFS_CTL_A, r.a);
    wr(HBC_OFS_CTL_B, r.b);
    @(posedge clock);
    bus <= '{r.ba, r.bd, r.f[3], 1'b1, r.f[2], r.f[1]};
    dbg_enable <= r.f[0];
    repeat (n) @(posedge clock);
    bus.valid <= 1'b0;
    #1 `CHK("brk_req", r.e[1], brk_req)
    if (r.e[1]) `CHK("brk_is_swi", r.e[0], brk_is_swi)
    k = 0;
    while ((brk_req | (dbg_active & ~dbg_force)) && k < 30) begin
      @(posedge clock);
      #1 k++;
    end
    if (brk_req | (dbg_active & ~dbg_force)) begin
      fail_count++;
      test_done();
    end
    // No match is queued behind a cleared request
    @(posedge clock);
    #1 `CHK("brk_req", 1'b0, brk_req)
  endtask : cyc

  // Main sequence
  initial begin
    nrst = 1'b0; req = '0; bus = '0; dbg_enable = 1'b0; dbg_force = 1'b0; dly = 3'h3;
    repeat (8) @(posedge clock);
    #1 `CHK("brk_req", 1'b0, brk_req)
    `CHK("brk_is_swi", 1'b0, brk_is_swi)
    @(posedge clock);
    nrst <= 1'b1;
    rd(HBC_OFS_CTL_A, 8'h00);
    wr(HBC_OFS_CTL_A, 8'hff);
    rd(HBC_OFS_CTL_A, 8'hec);
    wr(16'h0030, 8'h5a);
    rd(16'h0030, 8'h00);
    wr(HBC_OFS_AH, 8'h12); wr(HBC_OFS_AL, 8'h34);
    wr(HBC_OFS_DH, 8'h56); wr(HBC_OFS_DL, 8'h78);
    rd(HBC_OFS_DL, 8'h78);
    foreach (rows[i]) cyc(rows[i], 1);
    // Matches are suppressed while debug is active
    dbg_force <= 1'b1;
    cyc('{8'hc4, 8'h00, 16'h1234, 16'h0, 4'h1, 2'h0}, 1);
    dbg_force <= 1'b0;
    // Prompt ack with a second match while the request is held: dropped
    dly <= 3'h0;
    cyc('{8'h44, 8'h00, 16'h1234, 16'h0, 4'h6, 2'h3}, 2);
    test_done();
  end

  // Cuts a hang short
  initial begin
    #200000;
    fail_count++;
    test_done();
  end
endmodule : tb_top
